// >>> rtl/ccp_pkg.sv
// constants, register map and carrier types of the capture/compare/pwm pair
// assumes one aclk domain; timers and converter sit outside this block
package ccp_pkg;
   // byte addresses on the register bus, one word each;
   // control registers sit at four times their register index
   localparam logic [7:0] CCP_IDX_ONE_CTRL   = 8'h17;
   localparam logic [7:0] CCP_IDX_TWO_CTRL   = 8'h1d;
   localparam logic [7:0] CCP_ADDR_ONE_CTRL  = CCP_IDX_ONE_CTRL << 2;
   localparam logic [7:0] CCP_ADDR_TWO_CTRL  = CCP_IDX_TWO_CTRL << 2;
   localparam logic [7:0] CCP_ADDR_ONE_LOW   = 8'h40;
   localparam logic [7:0] CCP_ADDR_ONE_HIGH  = 8'h44;
   localparam logic [7:0] CCP_ADDR_TWO_LOW   = 8'h48;
   localparam logic [7:0] CCP_ADDR_TWO_HIGH  = 8'h4c;
   localparam logic [7:0] CCP_ADDR_STATUS    = 8'h50;
   localparam logic [7:0] CCP_ADDR_ENABLE    = 8'h54;
   localparam logic [7:0] CCP_ADDR_CLEAR     = 8'h58;
   localparam logic [5:0] CCP_CTRL_RESET     = 6'h00;
   localparam logic [1:0] CCP_RESP_OKAY      = 2'b00;
   localparam logic [1:0] CCP_RESP_SLVERR    = 2'b10;
   localparam int         CCP_CAP_DIV4       = 4;
   localparam int         CCP_CAP_DIV16      = 16;
   // status bits: [0] unit one event, [1] unit two event
   localparam int         CCP_NUM_EVENTS     = 2;

   typedef enum logic [3:0] {
      CCP_MODE_OFF      = 4'h0,
      CCP_MODE_CAP_FALL = 4'h4,
      CCP_MODE_CAP_RISE = 4'h5,
      CCP_MODE_CAP_R4   = 4'h6,
      CCP_MODE_CAP_R16  = 4'h7,
      CCP_MODE_CMP_SET  = 4'h8,
      CCP_MODE_CMP_CLR  = 4'h9,
      CCP_MODE_CMP_SW   = 4'ha,
      CCP_MODE_CMP_TRIG = 4'hb
   } ccp_mode_t;

   typedef struct packed {
      logic       duty_lsb_high;
      logic       duty_lsb_low;
      logic [3:0] unit_mode_select;
   } ccp_ctrl_t;

   typedef struct packed {
      logic [15:0] timer_one_count;
      logic [7:0]  timer_two_count;
      logic        timer_two_period;
   } ccp_time_t;
endpackage

// >>> rtl/ccp_unit.sv
// one capture/compare/pwm unit
// assumes timer counts and the period event are synchronous to aclk
`timescale 1ns/10ps
module ccp_unit (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire ccp_pkg::ccp_ctrl_t ctrl,
   input  wire ccp_pkg::ccp_time_t tb,
   input  wire logic             pin_in,
   input  wire logic             wr_low,
   input  wire logic             wr_high,
   input  wire logic [7:0]       wr_data,
   output logic [15:0]           value,
   output logic                  event_pulse,
   output logic                  trigger,
   output logic                  pin_out
);
   import ccp_pkg::*;

   // the low byte and ctrl duty_lsb_high/duty_lsb_low set the duty; the high byte is unused in pwm
   logic [7:0]  duty_latch;
   logic [1:0]  duty_lsb_latch;
   logic [3:0]  pre_cnt;
   logic        pin_prev;
   logic        cmp_done;
   logic [1:0]  pwm_sub;

   wire [3:0] mode     = ctrl.unit_mode_select;
   wire       is_cap   = mode[3:2] == 2'b01;
   wire       is_cmp   = mode[3:2] == 2'b10;
   wire       is_pwm   = mode[3:2] == 2'b11;
   wire       rise     = pin_in & ~pin_prev;
   wire       fall     = ~pin_in & pin_prev;
   wire       pre_wrap = (mode == CCP_MODE_CAP_R4) ?
                         (pre_cnt == 4'(CCP_CAP_DIV4 - 1)) :
                         (pre_cnt == 4'(CCP_CAP_DIV16 - 1));
   wire       cap_hit  = (mode == CCP_MODE_CAP_FALL) ? fall :
                         (mode == CCP_MODE_CAP_RISE) ? rise :
                         (is_cap & rise & pre_wrap);
   wire       cmp_hit  = is_cmp & ~cmp_done &
                         (tb.timer_one_count == value);
   // pwm on timer two with two extra fractional bits
   wire [9:0] pwm_pos  = {tb.timer_two_count, pwm_sub};
   wire [9:0] pwm_duty = {duty_latch, duty_lsb_latch};

   ///////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         value <= 16'h0000;
      end else if (is_cap && cap_hit) begin
         value <= tb.timer_one_count;
      end else if (wr_low) begin
         value[7:0] <= wr_data;
      end else if (wr_high) begin
         value[15:8] <= wr_data;
      end
   end

   // prescaler clears whenever not capturing on a divided edge
   always_ff @(posedge aclk) begin
      if (!aresetn || !is_cap || mode[1] == 1'b0) begin
         pre_cnt <= 4'h0;
      end else if (rise) begin
         pre_cnt <= pre_wrap ? 4'h0 : pre_cnt + 4'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_prev <= 1'b0;
         cmp_done <= 1'b0;
         pwm_sub  <= 2'b00;
         duty_latch     <= 8'h00;
         duty_lsb_latch <= 2'b00;
      end else begin
         pin_prev <= pin_in;
         // a match fires once until the count moves off the value
         cmp_done <= is_cmp & (tb.timer_one_count == value);
         // duty reload only on the shared period event
         if (tb.timer_two_period) begin
            pwm_sub        <= 2'b00;
            duty_latch     <= value[7:0];
            duty_lsb_latch <= {ctrl.duty_lsb_high, ctrl.duty_lsb_low};
         end else begin
            pwm_sub <= pwm_sub + 2'b01;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         event_pulse <= 1'b0;
         trigger     <= 1'b0;
         pin_out     <= 1'b0;
      end else begin
         // capture or compare match raises the event
         event_pulse <= (is_cap & cap_hit) | cmp_hit;
         // trigger from compare match in trigger mode
         trigger     <= cmp_hit & (mode == CCP_MODE_CMP_TRIG);
         if (is_pwm) begin
            pin_out <= pwm_pos < pwm_duty;
         end else if (cmp_hit && mode == CCP_MODE_CMP_SET) begin
            pin_out <= 1'b1;
         end else if (cmp_hit && mode == CCP_MODE_CMP_CLR) begin
            pin_out <= 1'b0;
         end else if (!is_cmp) begin
            pin_out <= 1'b0;
         end
      end
   end
endmodule

// >>> rtl/ccp_pair.sv
// top of the capture/compare/pwm pair with its axi4-lite register slave
// assumes timer counts, period event and pins are synchronous to aclk;
// timer one clears on timer_one_reset, converter starts on adc_start
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
module ccp_pair (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire ccp_pkg::ccp_time_t time_base,
   input  wire logic              adc_enabled,
   input  wire logic              unit_one_pin_in,
   input  wire logic              unit_two_pin_in,
   output logic                   unit_one_pin_out,
   output logic                   unit_two_pin_out,
   output logic                   timer_one_reset,
   output logic                   adc_start,
   output logic                   irq
);
   import ccp_pkg::*;

   localparam int NU = CCP_NUM_EVENTS;

   ccp_ctrl_t   ctrl       [NU];
   logic [15:0] value      [NU];
   logic [NU-1:0] ev;
   logic [NU-1:0] trig;
   logic [NU-1:0] pin_o;
   logic [NU-1:0] pin_i;
   logic [NU-1:0] status;
   logic [NU-1:0] enable;
   logic [7:0]  aw_addr;
   logic        w_lane0;
   logic        aw_have;
   logic        w_have;
   logic [7:0]  wr_byte;

   assign pin_i = {unit_two_pin_in, unit_one_pin_in};

   ///////////////////////////////////////////////////////////////////////
   // write channel: address and data taken in either order
   wire do_write = aw_have & w_have & ~s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have <= 1'b0;
         w_have  <= 1'b0;
         aw_addr <= 8'h00;
         w_lane0 <= 1'b0;
         s_axi_bvalid <= 1'b0;
         wr_byte <= 8'h00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            // strobe is kept with its data; the live wstrb may have moved on
            w_lane0 <= s_axi_wstrb[0];
            wr_byte <= s_axi_wdata[7:0];
         end
         if (do_write) begin
            aw_have <= 1'b0;
            w_have  <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   assign s_axi_awready = ~aw_have & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_have & ~s_axi_bvalid;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == CCP_ADDR_ONE_CTRL) || (a == CCP_ADDR_TWO_CTRL) ||
               (a == CCP_ADDR_ONE_LOW)  || (a == CCP_ADDR_ONE_HIGH) ||
               (a == CCP_ADDR_TWO_LOW)  || (a == CCP_ADDR_TWO_HIGH) ||
               (a == CCP_ADDR_STATUS)   || (a == CCP_ADDR_ENABLE)   ||
               (a == CCP_ADDR_CLEAR);
   endfunction

   assign s_axi_bresp = CCP_RESP_OKAY;
   // byte write only when lane zero is strobed
   wire wr_ok = do_write & w_lane0;
   wire [NU-1:0] wr_ctrl = {wr_ok & (aw_addr == CCP_ADDR_TWO_CTRL),
                            wr_ok & (aw_addr == CCP_ADDR_ONE_CTRL)};
   wire [NU-1:0] wr_low  = {wr_ok & (aw_addr == CCP_ADDR_TWO_LOW),
                            wr_ok & (aw_addr == CCP_ADDR_ONE_LOW)};
   wire [NU-1:0] wr_high = {wr_ok & (aw_addr == CCP_ADDR_TWO_HIGH),
                            wr_ok & (aw_addr == CCP_ADDR_ONE_HIGH)};
   wire wr_en  = wr_ok & (aw_addr == CCP_ADDR_ENABLE);
   wire wr_clr = wr_ok & (aw_addr == CCP_ADDR_CLEAR);

   ///////////////////////////////////////////////////////////////////////
   genvar u;
   generate
      for (u = 0; u < NU; u++) begin : g_unit
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               ctrl[u] <= ccp_ctrl_t'(CCP_CTRL_RESET);
            end else if (wr_ctrl[u]) begin
               ctrl[u] <= ccp_ctrl_t'(wr_byte[5:0]);
            end
         end
         ccp_unit i_unit (
            .aclk        (aclk),
            .aresetn     (aresetn),
            .ctrl        (ctrl[u]),
            .tb          (time_base),
            .pin_in      (pin_i[u]),
            .wr_low      (wr_low[u]),
            .wr_high     (wr_high[u]),
            .wr_data     (wr_byte),
            .value       (value[u]),
            .event_pulse (ev[u]),
            .trigger     (trig[u]),
            .pin_out     (pin_o[u])
         );
      end
   endgenerate

   ///////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status <= '0;
         enable <= '0;
         irq    <= 1'b0;
         timer_one_reset  <= 1'b0;
         adc_start        <= 1'b0;
         unit_one_pin_out <= 1'b0;
         unit_two_pin_out <= 1'b0;
      end else begin
         // sticky flag, a new event beats the clear
         status <= (status & ~(wr_clr ? wr_byte[NU-1:0] : '0)) | ev;
         if (wr_en) begin
            enable <= wr_byte[NU-1:0];
         end
         irq <= |(status & enable);
         timer_one_reset <= |trig;
         // conversion start from unit two only
         adc_start <= trig[1] & adc_enabled;
         unit_one_pin_out <= pin_o[0];
         unit_two_pin_out <= pin_o[1];
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // read channel, one cycle latency
   wire [31:0] rd_mux =
      (s_axi_araddr == CCP_ADDR_ONE_CTRL) ? {26'h0, ctrl[0]} :
      (s_axi_araddr == CCP_ADDR_TWO_CTRL) ? {26'h0, ctrl[1]} :
      (s_axi_araddr == CCP_ADDR_ONE_LOW)  ? {24'h0, value[0][7:0]} :
      (s_axi_araddr == CCP_ADDR_ONE_HIGH) ? {24'h0, value[0][15:8]} :
      (s_axi_araddr == CCP_ADDR_TWO_LOW)  ? {24'h0, value[1][7:0]} :
      (s_axi_araddr == CCP_ADDR_TWO_HIGH) ? {24'h0, value[1][15:8]} :
      (s_axi_araddr == CCP_ADDR_STATUS)   ? {30'h0, status} :
      (s_axi_araddr == CCP_ADDR_ENABLE)   ? {30'h0, enable} :
      32'h0000_0000;

   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= CCP_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= mapped(s_axi_araddr) ? CCP_RESP_OKAY :
                                                CCP_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// >>> tb/ccp_pair_assertions.sv
// port assertions of the capture/compare/pwm pair
// assumes one aclk domain; bound into ccp_pair at the foot
`timescale 1ns/10ps
module ccp_pair_assertions (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        adc_enabled,
   input wire logic        timer_one_reset,
   input wire logic        adc_start
);
   import ccp_pkg::*;
   logic [7:0] rd_addr;
   wire        rd_ctrl;
   wire        rd_known;
   assign rd_ctrl  = rd_addr == CCP_ADDR_ONE_CTRL ||
                     rd_addr == CCP_ADDR_TWO_CTRL;
   assign rd_known = rd_ctrl || (rd_addr[1:0] == 2'b00 &&
                     rd_addr >= CCP_ADDR_ONE_LOW && rd_addr <= CCP_ADDR_CLEAR);
   // address of the read in flight, to judge its answer
   always_ff @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) begin
         rd_addr <= s_axi_araddr;
      end
   end
   //////////////////////////////////////////////////
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write left unanswered");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read left unanswered");
   a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_write_okay: assert property (s_axi_bvalid |->
      s_axi_bresp == CCP_RESP_OKAY) else $error("write response not okay");
   a_unmapped_err: assert property (s_axi_rvalid && !rd_known |->
      s_axi_rresp == CCP_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read answered wrongly");
   a_ctrl_upper: assert property (s_axi_rvalid && rd_ctrl |->
      s_axi_rdata[31:6] == 26'h000_0000 && s_axi_rresp == CCP_RESP_OKAY)
      else $error("control upper bits not zero");
   a_adc_with_clear: assert property (adc_start |->
      timer_one_reset && $past(adc_enabled))
      else $error("conversion start without timer clear");
   a_clear_single: assert property (timer_one_reset |=>
      !timer_one_reset) else $error("timer clear longer than a cycle");
endmodule
bind ccp_pair ccp_pair_assertions u_ccp_pair_assertions (.*);

// >>> tb/ccp_timer_model.sv
// stand-in for timer one and timer two feeding the pair
// assumes the bench freezes timer one through run_one
`timescale 1ns/10ps
module ccp_timer_model (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          run_one,
   input  wire logic          timer_one_reset,
   output ccp_pkg::ccp_time_t time_base
);
   import ccp_pkg::*;
   // short period keeps pwm runs brief
   localparam logic [7:0] PERIOD = 8'h0f;
   //////////////////////////////////////////////////
   // counts, clear, period event
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         time_base <= '0;
      end else begin
         if (timer_one_reset) begin
            time_base.timer_one_count <= 16'h0000;
         end else if (run_one) begin
            time_base.timer_one_count <= time_base.timer_one_count + 16'h0001;
         end
         time_base.timer_two_period <= time_base.timer_two_count == PERIOD;
         if (time_base.timer_two_count == PERIOD) begin
            time_base.timer_two_count <= 8'h00;
         end else begin
            time_base.timer_two_count <= time_base.timer_two_count + 8'h01;
         end
      end
   end
endmodule

// >>> tb/testbench.sv
// register-level bench of the capture/compare/pwm pair
// assumes ccp_pair, its bound checker and ccp_timer_model are compiled
`timescale 1ns/10ps
module testbench;
   import ccp_pkg::*;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_bready, s_axi_rready, adc_enabled;
   logic        run_one, unit_one_pin_in, unit_two_pin_in, irq;
   logic        unit_one_pin_out, unit_two_pin_out, timer_one_reset;
   logic        adc_start;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [3:0]  s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [15:0] cnt;
   ccp_time_t   time_base;
   logic [7:0]  ctrl_a [2] = '{CCP_ADDR_ONE_CTRL, CCP_ADDR_TWO_CTRL};
   logic [7:0]  low_a [2]  = '{CCP_ADDR_ONE_LOW, CCP_ADDR_TWO_LOW};
   logic [7:0]  high_a [2] = '{CCP_ADDR_ONE_HIGH, CCP_ADDR_TWO_HIGH};
   int          n_errors = 0;
   int          samples_checked = 0;
   int          hits;
   ccp_pair        u_ccp_pair (.*);
   ccp_timer_model u_ccp_timer_model (.*);
   //////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, exp, input string msg);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s %h not %h", $time, msg, seen, exp);
      end
   endtask
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      bit aw = 0;
      bit w = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
   endtask
   task automatic rd_check(input logic [7:0] a, input logic [1:0] r,
                           input logic [31:0] exp, input string msg);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      check({30'h0000_0000, s_axi_rresp}, {30'h0000_0000, r}, msg);
      check(s_axi_rdata, exp, msg);
   endtask
   task automatic step_capture;
      run_one <= 1'b1;
      repeat (5) @(posedge aclk);
      run_one <= 1'b0;
      repeat (2) @(posedge aclk);
      cnt = time_base.timer_one_count;
      pins(1'b1);
      pins(1'b0);
   endtask
   task automatic pins(input logic v);
      unit_one_pin_in <= v;
      unit_two_pin_in <= v;
      repeat (4) @(posedge aclk);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      finish_test();
   end
   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, adc_enabled} = 4'h0;
      {unit_one_pin_in, unit_two_pin_in} = 2'h0;
      {s_axi_bready, s_axi_rready, run_one} = 3'h7;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
      s_axi_wstrb = 4'h1;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd_check(8'hfc, CCP_RESP_SLVERR, 32'h0000_0000, "unmapped");
      for (int u = 0; u < 2; u++) begin
         rd_check(ctrl_a[u], CCP_RESP_OKAY, 32'h0000_0000, "ctrl rst");
         axi_write(ctrl_a[u], 32'hffff_ffff);
         rd_check(ctrl_a[u], CCP_RESP_OKAY, 32'h0000_003f, "ctrl");
         axi_write(ctrl_a[u], 32'h0000_0000);
         axi_write(low_a[u], 32'h0000_00a5 + u);
         axi_write(high_a[u], 32'h0000_003c - u);
         rd_check(low_a[u], CCP_RESP_OKAY, 32'h0000_00a5 + u, "low");
         rd_check(high_a[u], CCP_RESP_OKAY, 32'h0000_003c - u, "high");
      end
      axi_write(CCP_ADDR_ENABLE, 32'h0000_0003);
      for (int u = 0; u < 2; u++) begin
         axi_write(ctrl_a[u], u ? CCP_MODE_CAP_FALL : CCP_MODE_CAP_RISE);
         // second capture lands before any read of the first
         repeat (2) step_capture();
         rd_check(low_a[u], CCP_RESP_OKAY, cnt[7:0], "cap low");
         rd_check(high_a[u], CCP_RESP_OKAY, cnt[15:8], "cap high");
         rd_check(CCP_ADDR_STATUS, CCP_RESP_OKAY, 32'h0000_0001 << u, "flag");
         check(irq, 32'h0000_0001, "irq on");
         axi_write(ctrl_a[u], 32'h0000_0000);
         axi_write(CCP_ADDR_CLEAR, 32'h0000_0001 << u);
         rd_check(CCP_ADDR_STATUS, CCP_RESP_OKAY, 32'h0000_0000, "clr");
         check(irq, 32'h0000_0000, "irq off");
      end
      for (int k = 0; k < 3; k++) begin
         adc_enabled <= k == 1;
         run_one <= 1'b0;
         repeat (2) @(posedge aclk);
         cnt = time_base.timer_one_count + 16'h0040;
         axi_write(low_a[k != 0], cnt[7:0]);
         axi_write(high_a[k != 0], cnt[15:8]);
         axi_write(ctrl_a[k != 0], CCP_MODE_CMP_TRIG);
         run_one <= 1'b1;
         hits = 0;
         while (!timer_one_reset && hits < 200) begin
            @(posedge aclk);
            hits++;
         end
         check(timer_one_reset, 32'h0000_0001, "timer clear");
         check(adc_start, k == 1, "conversion");
         axi_write(ctrl_a[k != 0], 32'h0000_0000);
         axi_write(CCP_ADDR_CLEAR, 32'h0000_0003);
      end
      // compare set, then compare clear, on unit one's pin
      for (int k = 0; k < 2; k++) begin
         run_one <= 1'b0;
         repeat (2) @(posedge aclk);
         cnt = time_base.timer_one_count + 16'h0040;
         axi_write(low_a[0], cnt[7:0]);
         axi_write(high_a[0], cnt[15:8]);
         axi_write(ctrl_a[0], k ? CCP_MODE_CMP_CLR : CCP_MODE_CMP_SET);
         run_one <= 1'b1;
         repeat (80) @(posedge aclk);
         check(unit_one_pin_out, 32'h0000_0001 - k, "compare pin");
      end
      // prescaled capture ignores the first three rising edges
      axi_write(low_a[1], 32'h0000_005a);
      axi_write(ctrl_a[1], CCP_MODE_CAP_R4);
      repeat (3) step_capture();
      rd_check(low_a[1], CCP_RESP_OKAY, 32'h0000_005a, "div4 early");
      step_capture();
      rd_check(low_a[1], CCP_RESP_OKAY, cnt[7:0], "div4 capture");
      for (int u = 0; u < 2; u++) begin
         axi_write(low_a[u], 32'h0000_0007);
         axi_write(ctrl_a[u], 32'h0000_000c);
      end
      // outputs agree only once both duties were reloaded
      repeat (40) @(posedge aclk);
      hits = 0;
      repeat (64) begin
         @(posedge aclk);
         check(unit_two_pin_out, unit_one_pin_out, "pwm pair");
         hits += unit_one_pin_out;
      end
      // duty 7 against a 16-count period: high for 7 of every 16 cycles
      check(hits, 32'h0000_001c, "pwm duty");
      finish_test();
   end
endmodule
